// >>> rtl/usdr_consts.vh
// Constants for the serial status and data register block
`ifndef USDR_CONSTS_VH
`define USDR_CONSTS_VH

// ==========================================================
// Register offsets
`define USDR_OFS_BAUD_HI   3'h0
`define USDR_OFS_BAUD_LO   3'h1
`define USDR_OFS_CTRL_ONE  3'h2
`define USDR_OFS_CTRL_TWO  3'h3
`define USDR_OFS_STAT_ONE  3'h4
`define USDR_OFS_STAT_TWO  3'h5
`define USDR_OFS_DATA_HI   3'h6
`define USDR_OFS_DATA_LO   3'h7

// ==========================================================
// Field positions
`define USDR_C1_NINE       4
`define USDR_C1_PAR_EN     1
`define USDR_C1_PAR_TYPE   0
`define USDR_C2_IR_EN      7
`define USDR_C2_ONE_WIRE   5
`define USDR_C2_TX_EN      3
`define USDR_C2_RX_EN      2
`define USDR_C2_BREAK      0
`define USDR_S2_ALTERNATE_MAP_SELECT       7
`define USDR_S2_TX_POLARITY      4
`define USDR_S2_RX_POLARITY      3
`define USDR_S2_LONG_BRK   2
`define USDR_S2_SINGLE_WIRE_TX_DIRECTION      1
`define USDR_DH_RX_NINTH   7
`define USDR_DH_TX_NINTH   6

// ==========================================================
// Reset values
`define USDR_RST_BYTE      8'h00
`define USDR_RST_BAUD_LO   8'h04

// ==========================================================
// Timing counts, in 16x sample ticks or bits
`define USDR_SMP_LAST      4'hf
`define USDR_SMP_A         4'h7
`define USDR_SMP_B         4'h8
`define USDR_SMP_C         4'h9
`define USDR_IRP_START     4'h7
`define USDR_IRP_END       4'h9
`define USDR_IR_STRETCH    5'h10
`define USDR_IDLE_EIGHT    9'h0a0
`define USDR_IDLE_NINE     9'h0b0
`define USDR_BITS_EIGHT    4'h8
`define USDR_BITS_NINE     4'h9
`define USDR_BRK_SHORT     4'ha
`define USDR_BRK_SHORT9    4'hb
`define USDR_BRK_LONG      4'hd
`define USDR_BRK_LONG9     4'he
`define USDR_FRM_EIGHT     4'ha
`define USDR_FRM_NINE      4'hb

`endif

// >>> rtl/usdr_regs.v
// Serial status, control and data registers with receiver and transmitter
// Function
// [R1] Overrun set when second frame completes unread
// [R2] Overrun frame discarded, data registers kept
// [R3] Overrun clears by status read, data read
// [R4] Overrun may stand without full; data read clears
// [R5] Noise flag set with full, not on overrun
// [R6] Framing flag set on zero stop bit
// [R7] Framing flag blocks reception until cleared
// [R8] Parity flag set on mismatch, parity enabled
// [R9] Alternate map switches offsets zero to two
// [R10] Transmit polarity inverts NRZ and infrared output
// [R11] Receive polarity inverts NRZ and infrared input
// [R12] Long break select sets break length
// [R13] Direction bit steers pin in single wire
// [R14] Receiver active set on start, cleared idle
// [R15] Low data register reads receive, writes transmit
// [R16] Ninth received bit in high bit seven
// [R17] Ninth transmit bit reused until rewritten
// [R18] Software writes high data before low
// [R19] Software leaves reserved high bits alone
// [R20] Full flag set on transfer, cleared by sequence
// [R21] Eight or nine data bits per character
// [R22] Data read without armed status read keeps flags
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "usdr_consts.vh"

module usdr_regs (
  input  wire       mclk,
  input  wire       rstn,
  input  wire [2:0] addr,
  input  wire [7:0] wr_data,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rd_data,
  input  wire       rxd_i,
  input  wire       txd_i,
  output reg        txd_o,
  output reg        txd_oe_n
);

  // ==========================================================
  // Register storage
  reg  [7:0] baud_high_reg;
  reg  [7:0] baud_low_reg;
  reg  [7:0] control_one_reg;
  reg  [7:0] control_two_reg;
  reg  [7:0] alt_status_one_reg;
  reg  [7:0] alt_control_one_reg;
  reg  [7:0] alt_control_two_reg;
  reg  [7:0] data_low_reg;
  reg  [7:0] tx_low_reg;
  reg        rx_ninth_bit;
  reg        tx_ninth_bit;
  reg        alternate_map_select;
  reg        tx_polarity;
  reg        rx_polarity;
  reg        long_break_select;
  reg        single_wire_tx_direction;
  reg        rx_active_flag;
  reg        rx_full_flag;
  reg        overrun_flag;
  reg        noise_flag;
  reg        framing_error_flag;
  reg        parity_error_flag;
  reg  [4:0] arm_reg;
  reg        tx_pend_reg;
  wire       tx_idle;

  wire nine_bit     = control_one_reg[`USDR_C1_NINE];
  wire parity_enable = control_one_reg[`USDR_C1_PAR_EN];
  wire parity_type  = control_one_reg[`USDR_C1_PAR_TYPE];
  wire ir_en        = control_two_reg[`USDR_C2_IR_EN];
  wire one_wire     = control_two_reg[`USDR_C2_ONE_WIRE];
  wire tx_en        = control_two_reg[`USDR_C2_TX_EN];
  wire rx_en        = control_two_reg[`USDR_C2_RX_EN];
  wire send_break   = control_two_reg[`USDR_C2_BREAK];

  wire [4:0] flags = {rx_full_flag, overrun_flag, noise_flag,
                      framing_error_flag, parity_error_flag};
  wire [7:0] status_one_reg = {~tx_pend_reg, tx_idle, 1'b0, 1'b0, 4'h0}
                              | {2'b00, rx_full_flag, 1'b0, overrun_flag,
                                 noise_flag, framing_error_flag, parity_error_flag};
  wire [7:0] status_two_reg = {alternate_map_select, 2'b00, tx_polarity, rx_polarity,
                               long_break_select, single_wire_tx_direction,
                               rx_active_flag};
  wire [7:0] data_high_reg  = {rx_ninth_bit, tx_ninth_bit, 6'h00};

  wire wr_hit_lo  = wr_stb && addr == `USDR_OFS_DATA_LO;
  wire rd_stat1   = rd_stb && addr == `USDR_OFS_STAT_ONE;
  wire rd_data_lo = rd_stb && addr == `USDR_OFS_DATA_LO;

  // ==========================================================
  // Pin synchronisers
  reg  [1:0] rxd_sync;
  reg  [1:0] txd_sync;
  always @(posedge mclk) begin
    if (!rstn) begin
      rxd_sync <= 2'b11;
      txd_sync <= 2'b11;
    end else begin
      rxd_sync <= {rxd_sync[0], rxd_i};
      txd_sync <= {txd_sync[0], txd_i};
    end
  end
  wire pin_in = one_wire ? txd_sync[1] : rxd_sync[1];

  // ==========================================================
  // Baud tick, sixteen per bit
  reg  [15:0] baud_cnt;
  reg         tick;
  wire [15:0] sbr = {baud_high_reg, baud_low_reg};
  always @(posedge mclk) begin
    if (!rstn) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (sbr == 16'h0000) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (baud_cnt >= sbr - 16'h0001) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // ==========================================================
  // Receive line decode, NRZ or stretched infrared pulses
  reg  [4:0] ir_stretch;
  wire       pin_pol = pin_in ^ rx_polarity; // R11
  always @(posedge mclk) begin
    if (!rstn)
      ir_stretch <= 5'h00;
    else if (pin_pol && ir_en)
      ir_stretch <= `USDR_IR_STRETCH;
    else if (tick && ir_stretch != 5'h00)
      ir_stretch <= ir_stretch - 5'h01;
  end
  wire line = ir_en ? (ir_stretch == 5'h00) : pin_pol; // R11

  // ==========================================================
  // Receiver
  localparam RX_IDLE = 1'b0;
  localparam RX_RECV = 1'b1;
  reg        rx_state;
  reg  [3:0] rx_smp;
  reg  [3:0] rx_bitn;
  reg        s_a;
  reg        s_b;
  reg        rx_noise;
  reg  [8:0] rx_shift;
  reg  [8:0] idle_cnt;
  reg        frame_done;
  reg        frame_stop;

  wire [3:0] nbits  = nine_bit ? `USDR_BITS_NINE : `USDR_BITS_EIGHT; // R21
  wire       maj    = (s_a & s_b) | (s_a & line) | (s_b & line);
  wire       disagr = ~(s_a == s_b && s_b == line);
  wire [8:0] idle_lim = nine_bit ? `USDR_IDLE_NINE : `USDR_IDLE_EIGHT;
  wire       idle_seen = idle_cnt >= idle_lim;
  wire [8:0] rx_aligned = nine_bit ? rx_shift : {1'b0, rx_shift[8:1]};

  always @(posedge mclk) begin
    if (!rstn) begin
      rx_state   <= RX_IDLE;
      rx_smp     <= 4'h0;
      rx_bitn    <= 4'h0;
      s_a        <= 1'b1;
      s_b        <= 1'b1;
      rx_noise   <= 1'b0;
      rx_shift   <= 9'h000;
      frame_done <= 1'b0;
      frame_stop <= 1'b1;
    end else begin
      frame_done <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          // First sample slot of the start search, blocked by framing error
          if (tick && rx_en && !line && !framing_error_flag) begin // R7
            rx_state <= RX_RECV;
            rx_smp   <= 4'h1;
            rx_bitn  <= 4'h0;
            rx_noise <= 1'b0;
          end
        end
        RX_RECV: begin
          if (!rx_en) begin
            rx_state <= RX_IDLE;
          end else if (tick) begin
            rx_smp <= rx_smp + 4'h1;
            if (rx_smp == `USDR_SMP_A)
              s_a <= line;
            if (rx_smp == `USDR_SMP_B)
              s_b <= line;
            if (rx_smp == `USDR_SMP_C) begin
              if (disagr)
                rx_noise <= 1'b1;
              if (rx_bitn == 4'h0 && maj)
                rx_state <= RX_IDLE;
              else if (rx_bitn == nbits + 4'h1) begin
                frame_done <= 1'b1;
                frame_stop <= maj;
                rx_state   <= RX_IDLE;
              end else if (rx_bitn != 4'h0)
                rx_shift <= {maj, rx_shift[8:1]};
            end
            if (rx_smp == `USDR_SMP_LAST)
              rx_bitn <= rx_bitn + 4'h1;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Idle character counter
  always @(posedge mclk) begin
    if (!rstn)
      idle_cnt <= 9'h000;
    else if (tick) begin
      if (!line)
        idle_cnt <= 9'h000;
      else if (!idle_seen)
        idle_cnt <= idle_cnt + 9'h001;
    end
  end

  // Receiver active flag
  always @(posedge mclk) begin
    if (!rstn)
      rx_active_flag <= 1'b0;
    else if (rx_state == RX_IDLE && tick && rx_en && !line && !framing_error_flag)
      rx_active_flag <= 1'b1; // R14
    else if (idle_seen)
      rx_active_flag <= 1'b0; // R14
  end

  // ==========================================================
  // Receive flags and data, set wins over clear
  wire       par_bad = parity_enable & ((^rx_aligned) ^ parity_type);
  wire       load_ok = frame_done && !rx_full_flag;
  wire       ovr_evt = frame_done && rx_full_flag;
  wire [4:0] clr     = rd_data_lo ? (arm_reg & flags) : 5'h00; // R22

  always @(posedge mclk) begin
    if (!rstn) begin
      arm_reg <= 5'h00;
    end else if (rd_stat1) begin
      arm_reg <= flags; // R3
    end else if (rd_data_lo) begin
      arm_reg <= 5'h00;
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      rx_full_flag       <= 1'b0;
      overrun_flag       <= 1'b0;
      noise_flag         <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
      data_low_reg       <= `USDR_RST_BYTE;
      rx_ninth_bit       <= 1'b0;
    end else begin
      if (load_ok) begin
        data_low_reg <= rx_aligned[7:0]; // R15
        rx_ninth_bit <= nine_bit & rx_aligned[8]; // R16
      end
      // Overrun frame is dropped, held data stays
      if (ovr_evt)
        overrun_flag <= 1'b1; // R1 R2
      else if (clr[3])
        overrun_flag <= 1'b0; // R3 R4
      if (load_ok)
        rx_full_flag <= 1'b1; // R20
      else if (clr[4])
        rx_full_flag <= 1'b0; // R20
      if (load_ok && rx_noise)
        noise_flag <= 1'b1; // R5
      else if (clr[2])
        noise_flag <= 1'b0; // R5
      if (load_ok && !frame_stop)
        framing_error_flag <= 1'b1; // R6
      else if (clr[1])
        framing_error_flag <= 1'b0; // R6
      if (load_ok && par_bad)
        parity_error_flag <= 1'b1; // R8
      else if (clr[0])
        parity_error_flag <= 1'b0; // R8
    end
  end

  // ==========================================================
  // Register writes
  always @(posedge mclk) begin
    if (!rstn) begin
      baud_high_reg            <= `USDR_RST_BYTE;
      baud_low_reg             <= `USDR_RST_BAUD_LO;
      control_one_reg          <= `USDR_RST_BYTE;
      control_two_reg          <= `USDR_RST_BYTE;
      alt_status_one_reg       <= `USDR_RST_BYTE;
      alt_control_one_reg      <= `USDR_RST_BYTE;
      alt_control_two_reg      <= `USDR_RST_BYTE;
      alternate_map_select     <= 1'b0;
      tx_polarity              <= 1'b0;
      rx_polarity              <= 1'b0;
      long_break_select        <= 1'b0;
      single_wire_tx_direction <= 1'b0;
      tx_ninth_bit             <= 1'b0;
      tx_low_reg               <= `USDR_RST_BYTE;
    end else if (wr_stb) begin
      case (addr)
        `USDR_OFS_BAUD_HI:
          if (alternate_map_select) alt_status_one_reg <= wr_data; // R9
          else baud_high_reg <= wr_data; // R9
        `USDR_OFS_BAUD_LO:
          if (alternate_map_select) alt_control_one_reg <= wr_data; // R9
          else baud_low_reg <= wr_data; // R9
        `USDR_OFS_CTRL_ONE:
          if (alternate_map_select) alt_control_two_reg <= wr_data; // R9
          else control_one_reg <= wr_data; // R9
        `USDR_OFS_CTRL_TWO: control_two_reg <= wr_data;
        `USDR_OFS_STAT_TWO: begin
          alternate_map_select     <= wr_data[`USDR_S2_ALTERNATE_MAP_SELECT];
          tx_polarity              <= wr_data[`USDR_S2_TX_POLARITY];
          rx_polarity              <= wr_data[`USDR_S2_RX_POLARITY];
          long_break_select        <= wr_data[`USDR_S2_LONG_BRK];
          single_wire_tx_direction <= wr_data[`USDR_S2_SINGLE_WIRE_TX_DIRECTION];
        end
        // Received-bit and reserved positions ignore writes
        `USDR_OFS_DATA_HI: tx_ninth_bit <= wr_data[`USDR_DH_TX_NINTH]; // R16 R17
        `USDR_OFS_DATA_LO: tx_low_reg <= wr_data; // R15
        default: tx_low_reg <= tx_low_reg;
      endcase
    end
  end

  // ==========================================================
  // Register reads, data one cycle later
  always @(posedge mclk) begin
    if (!rstn)
      rd_data <= `USDR_RST_BYTE;
    else if (rd_stb) begin
      case (addr)
        `USDR_OFS_BAUD_HI:  rd_data <= alternate_map_select ? alt_status_one_reg
                                                            : baud_high_reg; // R9
        `USDR_OFS_BAUD_LO:  rd_data <= alternate_map_select ? alt_control_one_reg
                                                            : baud_low_reg; // R9
        `USDR_OFS_CTRL_ONE: rd_data <= alternate_map_select ? alt_control_two_reg
                                                            : control_one_reg; // R9
        `USDR_OFS_CTRL_TWO: rd_data <= control_two_reg;
        `USDR_OFS_STAT_ONE: rd_data <= status_one_reg;
        `USDR_OFS_STAT_TWO: rd_data <= status_two_reg;
        `USDR_OFS_DATA_HI:  rd_data <= data_high_reg; // R16
        `USDR_OFS_DATA_LO:  rd_data <= data_low_reg; // R15
        default:            rd_data <= `USDR_RST_BYTE;
      endcase
    end else
      rd_data <= `USDR_RST_BYTE;
  end

  // ==========================================================
  // Transmitter
  reg  [3:0]  tx_phase;
  reg  [10:0] tx_shift;
  reg  [3:0]  tx_left;
  assign      tx_idle = (tx_left == 4'h0);
  wire        bit_tick = tick && tx_phase == `USDR_SMP_LAST;
  wire [3:0]  brk_len = long_break_select ? (nine_bit ? `USDR_BRK_LONG9 : `USDR_BRK_LONG)
                                          : (nine_bit ? `USDR_BRK_SHORT9
                                                      : `USDR_BRK_SHORT); // R12
  wire [3:0]  frm_len = nine_bit ? `USDR_FRM_NINE : `USDR_FRM_EIGHT;

  always @(posedge mclk) begin
    if (!rstn) begin
      tx_phase    <= 4'h0;
      tx_shift    <= 11'h7ff;
      tx_left     <= 4'h0;
      tx_pend_reg <= 1'b0;
    end else begin
      if (tick)
        tx_phase <= tx_phase + 4'h1;
      if (wr_hit_lo)
        tx_pend_reg <= 1'b1;
      if (bit_tick && tx_en) begin
        if (!tx_idle) begin
          // Top bit refills, so a break stays low past eleven bits
          tx_shift <= {tx_shift[10], tx_shift[10:1]}; // R12
          tx_left  <= tx_left - 4'h1;
        end else if (send_break) begin
          tx_shift <= 11'h000;
          tx_left  <= brk_len; // R12
        end else if (tx_pend_reg && !wr_hit_lo) begin
          // Ninth bit holds its value across frames
          tx_shift <= nine_bit ? {1'b1, tx_ninth_bit, tx_low_reg, 1'b0}
                               : {2'b11, tx_low_reg, 1'b0}; // R17 R21
          tx_left  <= frm_len;
          tx_pend_reg <= 1'b0;
        end
      end
    end
  end

  // Pin drive with polarity and infrared pulse
  wire tx_bit   = tx_idle ? 1'b1 : tx_shift[0];
  wire ir_win   = tx_phase >= `USDR_IRP_START && tx_phase <= `USDR_IRP_END;
  wire tx_level = ir_en ? ((~tx_bit & ir_win) ^ tx_polarity)
                        : (tx_bit ^ tx_polarity); // R10
  always @(posedge mclk) begin
    if (!rstn) begin
      txd_o    <= 1'b1;
      txd_oe_n <= 1'b1;
    end else begin
      txd_o    <= tx_level; // R10
      txd_oe_n <= ~(tx_en && (!one_wire || single_wire_tx_direction)); // R13
    end
  end

endmodule
`default_nettype wire

// >>> verif/usdr_regs_checker.sv
// Port checker for the serial status and data register block
`timescale 1ns/100ps
`default_nettype none
module usdr_regs_checker (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic       rxd_i,
  input wire logic       txd_i,
  input wire logic       txd_o,
  input wire logic       txd_oe_n
);
  logic [7:0] main_sh [2];
  logic [7:0] alt_sh [2];
  logic [7:0] s2_sh;
  logic [7:0] c2_sh;
  logic       t8_sh;
  logic [1:0] age;
  logic [7:0] map_exp;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // ==========
  // Shadow of writable fields
  assign map_exp = s2_sh[7] ? alt_sh[addr[0]] : main_sh[addr[0]];
  always @(posedge mclk) begin
    if (!rstn) begin
      main_sh[0] <= 8'h00;
      main_sh[1] <= 8'h04;
      alt_sh[0] <= 8'h00;
      alt_sh[1] <= 8'h00;
      s2_sh <= 8'h00;
      c2_sh <= 8'h00;
      t8_sh <= 1'b0;
      age <= 2'h0;
    end else begin
      if (wr_stb && addr[2:1] == 2'h0 && s2_sh[7])
        alt_sh[addr[0]] <= wr_data;
      if (wr_stb && addr[2:1] == 2'h0 && !s2_sh[7])
        main_sh[addr[0]] <= wr_data;
      if (wr_stb && addr == 3'h5)
        s2_sh <= wr_data & 8'h9e;
      if (wr_stb && addr == 3'h3)
        c2_sh <= wr_data;
      if (wr_stb && addr == 3'h6)
        t8_sh <= wr_data[6];
      if (wr_stb && (addr == 3'h3 || addr == 3'h5))
        age <= 2'h0;
      else if (age != 2'h3)
        age <= age + 2'h1;
    end
  end
  // ==========
  // Properties
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn |=> rd_data == 8'h00 && txd_o && txd_oe_n) else $error("outputs busy after reset");
  a_read_pulse: assert property (!rd_stb |=> rd_data == 8'h00)
    else $error("read data without read strobe");
  a_map_read: assert property (
    rd_stb && addr[2:1] == 2'h0 |=> rd_data == $past(map_exp)) else $error("wrong map read");
  a_stat_two_read: assert property (
    rd_stb && addr == 3'h5 |=> (rd_data & 8'h9e) == $past(s2_sh)) else $error("status two lost");
  a_ninth_tx_read: assert property (
    rd_stb && addr == 3'h6 |=> rd_data[6] == $past(t8_sh)) else $error("ninth tx bit lost");
  a_oe_plain: assert property (
    age == 2'h3 && c2_sh[3] && !c2_sh[5] |-> !txd_oe_n) else $error("pin not driven");
  a_oe_wire_in: assert property (
    age == 2'h3 && c2_sh[5] && !s2_sh[1] |-> txd_oe_n) else $error("input pin driven");
  a_oe_wire_out: assert property (
    age == 2'h3 && c2_sh[5] && s2_sh[1] && c2_sh[3] |-> !txd_oe_n) else $error("output undriven");
  c_alt_read: cover property (rd_stb && addr == 3'h1 && s2_sh[7]);
  c_wire_in: cover property (age == 2'h3 && c2_sh[5] && !s2_sh[1]);
  c_full_read: cover property (rd_stb && addr == 3'h4 ##1 rd_data[5]);
endmodule
`default_nettype wire

// >>> verif/usdr_remote.sv
// Remote serial device: sends frames to the receiver, captures sent frames
`timescale 1ns/100ps
`default_nettype none
module usdr_remote #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic mclk,
  input  wire logic rx_line,
  output var  logic tx_line
);
  logic inv;
  initial begin
    inv = 1'b0;
    tx_line = 1'b1;
  end
  // ==========
  // Line polarity, idle follows it
  task automatic set_inv(input logic v);
    inv = v;
    tx_line <= ~v;
  endtask
  // ==========
  // Start, data LSB first, stop; gl picks a bit to glitch
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input int gl);
    logic b;
    for (int i = 0; i <= nb + 1; i++) begin
      b = (i == 0) ? 1'b0 : (i <= nb) ? d[i - 1] : stp;
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge mclk);
        tx_line <= b ^ inv ^ (i == gl && c >= 29 && c < 33);
      end
    end
    @(posedge mclk);
    tx_line <= ~inv;
  endtask
  // ==========
  // Capture one frame at bit centres
  task automatic get(input int nb, output logic [8:0] d, output logic stp);
    d = 9'h000;
    stp = 1'b0;
    while (rx_line !== 1'b0)
      @(posedge mclk);
    repeat (BIT_CLKS / 2) @(posedge mclk);
    for (int i = 0; i <= nb; i++) begin
      repeat (BIT_CLKS) @(posedge mclk);
      if (i < nb)
        d[i] = rx_line;
      else
        stp = rx_line;
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/usdr_regs_bench.sv
// Self-checking bench for the serial status and data register block
`timescale 1ns/100ps
`default_nettype none
module usdr_regs_bench;
  logic        mclk;
  logic        rstn;
  logic [2:0]  addr;
  logic [7:0]  wr_data;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rd_data;
  logic        rxd;
  logic        txd_pin;
  logic        txd_o;
  logic        txd_oe_n;
  int          miscompares;
  int          check_count;
  int          cyc;
  logic [8:0]  fd;
  logic        fs;
  logic [15:0] n;
  // Control two, status two, idle level, active-low output enable
  localparam logic [17:0] ROWS [7] = '{18'h02002, 18'h02040, 18'h22000, 18'h22042,
                                      18'h0a001, 18'h0a00a, 18'h0200a};
  assign txd_pin = txd_oe_n ? 1'b1 : txd_o;
  usdr_regs DUT (
    .mclk(mclk),
    .rstn(rstn),
    .addr(addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rd_data(rd_data),
    .rxd_i(rxd),
    .txd_i(txd_pin),
    .txd_o(txd_o),
    .txd_oe_n(txd_oe_n)
  );
  usdr_remote #(.BIT_CLKS(64)) u_rem (
    .mclk(mclk),
    .rx_line(txd_pin),
    .tx_line(rxd)
  );
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares = miscompares + 1;
      print_verdict();
    end
  end
  // ==========
  // Bus and compare tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(posedge mclk);
    d = rd_data;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d & m}, {8'h00, e});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    miscompares = 0;
    check_count = 0;
    cyc = 0;
    mclk = 1'b0;
    rstn = 1'b0;
    addr = 3'h0;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rc(3'h7, 8'hff, 8'h00);
    rc(3'h4, 8'h2f, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(3'h3, ROWS[i][17:10]);
      wr(3'h5, ROWS[i][9:2]);
      repeat (8) @(posedge mclk);
      chk({15'h0000, txd_oe_n}, {15'h0000, ROWS[i][0]});
      if (!ROWS[i][0])
        chk({15'h0000, txd_o}, {15'h0000, ROWS[i][1]});
    end
    wr(3'h5, 8'h00);
    wr(3'h3, 8'h0c);
    wr(3'h5, 8'h80);
    wr(3'h0, 8'h5a);
    wr(3'h1, 8'hc3);
    rc(3'h1, 8'hff, 8'hc3);
    rc(3'h0, 8'hff, 8'h5a);
    wr(3'h5, 8'h00);
    rc(3'h1, 8'hff, 8'h04);
    rc(3'h0, 8'hff, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(3'h2, {3'h0, k[0], 4'h0});
      wr(3'h5, {5'h00, k[1], 2'h0});
      wr(3'h3, 8'h0d);
      while (txd_o !== 1'b0)
        @(posedge mclk);
      wr(3'h3, 8'h0c);
      n = 16'h0002;
      while (txd_o === 1'b0) begin
        n = n + 16'h0001;
        @(posedge mclk);
      end
      chk(n, ((k[1] ? 16'h000d : 16'h000a) + {15'h0000, k[0]}) * 16'h0040);
      repeat (100) @(posedge mclk);
    end
    wr(3'h2, 8'h10);
    wr(3'h5, 8'h00);
    wr(3'h6, 8'h40);
    wr(3'h7, 8'ha5);
    u_rem.get(9, fd, fs);
    chk({7'h00, fd}, 16'h01a5);
    wr(3'h7, 8'h3c);
    u_rem.get(9, fd, fs);
    chk({7'h00, fd}, 16'h013c);
    chk({15'h0000, fs}, 16'h0001);
    repeat (64) @(posedge mclk);
    wr(3'h2, 8'h00);
    u_rem.send(9'h03c, 8, 1'b1, -1);
    rc(3'h7, 8'hff, 8'h3c);
    rc(3'h4, 8'h2f, 8'h20);
    rc(3'h7, 8'hff, 8'h3c);
    rc(3'h4, 8'h2f, 8'h00);
    u_rem.send(9'h011, 8, 1'b1, -1);
    rc(3'h4, 8'h2f, 8'h20);
    u_rem.send(9'h022, 8, 1'b1, -1);
    rc(3'h7, 8'hff, 8'h11);
    rc(3'h4, 8'h2f, 8'h08);
    rc(3'h7, 8'hff, 8'h11);
    rc(3'h4, 8'h2f, 8'h00);
    u_rem.send(9'h055, 8, 1'b0, -1);
    rc(3'h4, 8'h2f, 8'h22);
    u_rem.send(9'h066, 8, 1'b1, -1);
    rc(3'h4, 8'h2f, 8'h22);
    rc(3'h7, 8'hff, 8'h55);
    rc(3'h4, 8'h2f, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(3'h2, {6'h00, 1'b1, k[1]});
      u_rem.send({1'b0, k[1] ^ k[0], 7'h35}, 8, 1'b1, -1);
      rc(3'h4, 8'h2f, {7'h10, k[0]});
      rc(3'h7, 8'h7f, 8'h35);
    end
    wr(3'h2, 8'h00);
    u_rem.send(9'h00f, 8, 1'b1, 3);
    rc(3'h4, 8'h2f, 8'h24);
    rc(3'h7, 8'hff, 8'h0f);
    wr(3'h2, 8'h10);
    u_rem.send(9'h1a5, 9, 1'b1, -1);
    wr(3'h6, 8'h00);
    rc(3'h6, 8'h80, 8'h80);
    rc(3'h4, 8'h2f, 8'h20);
    rc(3'h7, 8'hff, 8'ha5);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h08);
    wr(3'h5, 8'h08);
    u_rem.set_inv(1'b1);
    repeat (8) @(posedge mclk);
    wr(3'h3, 8'h0c);
    fork
      u_rem.send(9'h05a, 8, 1'b1, -1);
      begin
        repeat (300) @(posedge mclk);
        rc(3'h5, 8'h01, 8'h01);
      end
    join
    rc(3'h4, 8'h2f, 8'h20);
    rc(3'h7, 8'hff, 8'h5a);
    repeat (900) @(posedge mclk);
    rc(3'h5, 8'h01, 8'h00);
    print_verdict();
  end
endmodule
bind usdr_regs usdr_regs_checker u_chk (
  .mclk(mclk),
  .rstn(rstn),
  .addr(addr),
  .wr_data(wr_data),
  .wr_stb(wr_stb),
  .rd_stb(rd_stb),
  .rd_data(rd_data),
  .rxd_i(rxd_i),
  .txd_i(txd_i),
  .txd_o(txd_o),
  .txd_oe_n(txd_oe_n)
);
`default_nettype wire
